//--- external_bus_cycle_phase_sequencer.sv
`include "ebus_seq_regs.svh"
`default_nettype none
module external_bus_cycle_phase_sequencer
    import ebus_seq_pkg::*;
#(
    parameter int AW = 24,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // phase time unit divider, cycles per unit minus one
    input  wire logic [7:0]    phase_time_unit,
    // chip select timing control
    input  wire logic [0:0]    address_setup_phase,
    input  wire logic [1:0]    address_window_extra,
    input  wire logic [1:0]    command_delay_phase,
    input  wire logic [0:0]    write_setup_tristate_phase,
    input  wire logic [4:0]    access_phase,
    input  wire logic [1:0]    hold_phase,
    input  wire logic          mux_mode,
    input  wire logic          ready_enable,
    input  wire logic          ready_active_high,
    input  wire logic          ready_async,
    // request side
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    input  wire logic          req_upper_byte,
    output logic               done_pulse,
    output logic [DW-1:0]      rd_data,
    // external pins
    output logic [AW-1:0]      separate_address_lines,
    output logic [DW-1:0]      shared_bus_lines_out,
    output logic               shared_bus_lines_oe_n,
    input  wire logic [DW-1:0] shared_bus_lines_in,
    output logic [DW-1:0]      separate_data_lines_out,
    output logic               separate_data_lines_oe_n,
    input  wire logic [DW-1:0] separate_data_lines_in,
    output logic               addr_latch_en,
    output logic               rd_n,
    output logic               wr_n,
    output logic               upper_byte_select_n,
    input  wire logic          ready_pin
);
    import ebus_seq_pkg::*;

    typedef struct packed {
        phase_e          ph;
        logic [5:0]      cnt;
        logic [7:0]      div;
        logic            wr;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
        logic            ub;
        logic [AW-1:16]  last_win;
        logic            win_valid;
        logic [DW-1:0]   rdata;
        logic            done;
        logic [1:0]      sync;
        logic            rdy_s;
    } state_s;

    state_s cur_reg;
    state_s cur_next;

    logic   tick;
    logic   rdy_now;
    logic   rdy_raw;
    logic   win_change;
    logic [5:0] ab_len;

    assign tick    = (cur_reg.div == `ZERO_DIV);
    assign rdy_raw = ready_pin ~^ ready_active_high;
    // async path: two-stage synchroniser plus one registered stage
    assign rdy_now = ready_async ? cur_reg.rdy_s : rdy_raw;
    assign win_change = !cur_reg.win_valid || (req_addr[AW-1:16] != cur_reg.last_win);
    assign ab_len = 6'(`AB_MIN) + 6'(address_setup_phase)
                  + (win_change ? 6'(address_window_extra) : `ZERO_CNT);

    function automatic logic [5:0] len_of(input phase_e p);
        case (p)
            PH_C:    len_of = 6'(command_delay_phase);
            PH_D:    len_of = 6'(write_setup_tristate_phase);
            PH_E:    len_of = 6'(access_phase) + `ONE_CNT;
            PH_F:    len_of = 6'(hold_phase);
            default: len_of = `ZERO_CNT;
        endcase
    endfunction

    // first nonzero phase at or after p
    function automatic phase_e skip_from(input phase_e p);
        phase_e q;
        q = p;
        if (q == PH_C && len_of(PH_C) == `ZERO_CNT) q = PH_D;
        if (q == PH_D && len_of(PH_D) == `ZERO_CNT) q = PH_E;
        skip_from = q;
    endfunction

    always_comb begin
        cur_next = cur_reg;
        cur_next.done = 1'b0;
        cur_next.sync = {cur_reg.sync[0], ready_pin ~^ ready_active_high};
        cur_next.rdy_s = cur_reg.sync[1];
        cur_next.div = tick ? phase_time_unit : cur_reg.div - `ONE_DIV;
        case (cur_reg.ph)
            PH_IDLE: begin
                cur_next.div = phase_time_unit;
                if (req_valid) begin
                    cur_next.ph = PH_AB;
                    cur_next.cnt = ab_len;
                    cur_next.wr = req_write;
                    cur_next.addr = req_addr;
                    cur_next.wdata = req_wdata;
                    cur_next.ub = req_upper_byte;
                    cur_next.last_win = req_addr[AW-1:16];
                    cur_next.win_valid = 1'b1;
                end
            end
            PH_AB, PH_C, PH_D: begin
                if (tick) begin
                    if (cur_reg.cnt == `ONE_CNT) begin
                        cur_next.ph = skip_from(cur_reg.ph == PH_AB ? PH_C :
                                                cur_reg.ph == PH_C ? PH_D : PH_E);
                        cur_next.cnt = len_of(cur_next.ph);
                    end else begin
                        cur_next.cnt = cur_reg.cnt - `ONE_CNT;
                    end
                end
            end
            PH_E, PH_RDY: begin
                if (tick) begin
                    if (cur_reg.cnt > `ONE_CNT) begin
                        cur_next.cnt = cur_reg.cnt - `ONE_CNT;
                    end else if (ready_enable && !rdy_now) begin
                        cur_next.ph = PH_RDY;
                        cur_next.cnt = `ONE_CNT;
                    end else begin
                        if (!cur_reg.wr) begin
                            // strobe rises on this edge; data latched in the same edge
                            cur_next.rdata = mux_mode ? shared_bus_lines_in : separate_data_lines_in;
                        end
                        cur_next.cnt = len_of(PH_F);
                        cur_next.ph = (len_of(PH_F) == `ZERO_CNT) ? PH_IDLE : PH_F;
                        cur_next.done = (len_of(PH_F) == `ZERO_CNT);
                    end
                end
            end
            PH_F: begin
                if (tick) begin
                    if (cur_reg.cnt == `ONE_CNT) begin
                        cur_next.ph = PH_IDLE;
                        cur_next.done = 1'b1;
                    end else begin
                        cur_next.cnt = cur_reg.cnt - `ONE_CNT;
                    end
                end
            end
            default: cur_next.ph = PH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    logic in_cmd;
    assign in_cmd = (cur_reg.ph == PH_E) || (cur_reg.ph == PH_RDY) ||
                    (cur_reg.ph == PH_D && cur_reg.wr);

    assign req_ready = (cur_reg.ph == PH_IDLE);
    assign done_pulse = cur_reg.done;
    assign rd_data = cur_reg.rdata;
    assign separate_address_lines = cur_reg.addr;
    assign addr_latch_en = (cur_reg.ph == PH_AB) && mux_mode;
    // multiplexed: address during setup, then write data or release
    // address stays on the shared lines through command delay, never stale write data
    assign shared_bus_lines_out = (cur_reg.ph == PH_AB || cur_reg.ph == PH_C) ?
                                  cur_reg.addr[DW-1:0] : cur_reg.wdata;
    assign shared_bus_lines_oe_n = !(mux_mode && (cur_reg.ph == PH_AB || cur_reg.ph == PH_C ||
                                   (cur_reg.wr && cur_reg.ph != PH_IDLE)));
    assign separate_data_lines_out = cur_reg.wdata;
    assign separate_data_lines_oe_n = !(!mux_mode && cur_reg.wr && cur_reg.ph != PH_IDLE);
    assign rd_n = !(in_cmd && !cur_reg.wr && cur_reg.ph != PH_D);
    assign wr_n = !(in_cmd && cur_reg.wr);
    assign upper_byte_select_n = !(cur_reg.ub && cur_reg.ph != PH_IDLE);

    order_ab_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_IDLE && req_valid) |=> cur_reg.ph == PH_AB) else $error("cycle did not start with setup");
    order_f_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cur_reg.ph == PH_F |-> $past(cur_reg.ph) inside {PH_E, PH_RDY, PH_F}) else $error("hold not after access");
    ab_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_AB) |-> cur_reg.cnt inside {[1:5]}) else $error("setup length out of range");
    skip_c_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_C) |-> command_delay_phase != 2'h0) else $error("zero phase entered");
    wait_rdy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_E && cur_reg.cnt == 6'h01 && tick && ready_enable && !rdy_now)
        |=> cur_reg.ph == PH_RDY) else $error("no wait state on not ready");
    end_rdy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_RDY && tick && rdy_now) |=> cur_reg.ph inside {PH_F, PH_IDLE}) else $error("ready ignored");
    rd_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($rose(rd_n) && !cur_reg.wr) |-> cur_reg.rdata == $past(mux_mode ? shared_bus_lines_in : separate_data_lines_in))
        else $error("read data not captured at strobe end");
    rd_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_E && !cur_reg.wr) |-> $stable(rd_data)) else $error("read data changed in access");
    oe_demux_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!wr_n && !mux_mode) |-> !separate_data_lines_oe_n) else $error("write data not driven");
    mux_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cur_reg.ph == PH_AB && mux_mode) |-> shared_bus_lines_out == cur_reg.addr[DW-1:0]) else $error("mux address wrong");
    cnt_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($changed(cur_reg.ph) && cur_reg.ph == PH_E) |-> cur_reg.cnt == 6'(access_phase) + 6'h01) else $error("access not loaded");

    rd_cycle_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(rd_n));
    wr_cycle_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(wr_n));
    rdy_wait_c: cover property (@(posedge core_clk) disable iff (!rst_n) cur_reg.ph == PH_RDY);
endmodule
`default_nettype wire

//--- ebus_seq_regs.svh
`ifndef EBUS_SEQ_REGS_SVH
`define EBUS_SEQ_REGS_SVH
`define TU_DIV_DEFAULT    8'h01
`define AB_MIN            3'h1
`define AB_EXT_MAX        3'h3
`define AE_WIDTH          5
`define ZERO_CNT          6'h00
`define ONE_CNT           6'h01
`define ZERO_DIV          8'h00
`define ONE_DIV           8'h01
`endif

//--- ebus_seq_pkg.sv
`default_nettype none
package ebus_seq_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_AB   = 3'b001,
        PH_C    = 3'b010,
        PH_D    = 3'b011,
        PH_E    = 3'b100,
        PH_RDY  = 3'b101,
        PH_F    = 3'b110
    } phase_e;
endpackage
`default_nettype wire

//--- ext_mem.sv
`default_nettype none
// external memory: answers reads, raises ready after a set delay
module ext_mem (
    // clock and strobes
    input  wire logic        core_clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [23:0] addr,
    // ready behaviour
    input  wire logic [3:0]  ready_wait,
    input  wire logic        ready_hi,
    // answers
    output var logic  [15:0] data,
    output logic             ready_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic       rdy;
    initial begin
        data = 16'h0000;
        cnt  = 4'h0;
        rdy  = 1'b0;
    end
    // released lines toggle so a late capture cannot pass
    always @(negedge core_clk) begin
        data <= !rd_n ? (addr[15:0] ^ 16'h3c5a) : ~data;
        if (rd_n && wr_n) begin
            cnt <= 4'h0;
            rdy <= 1'b0;
        end else if (cnt == ready_wait) begin
            rdy <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    assign ready_pin = ready_hi ? rdy : !rdy;
endmodule
`default_nettype wire

//--- external_bus_cycle_phase_sequencer_tb.sv
`default_nettype none
module external_bus_cycle_phase_sequencer_tb;
    import ebus_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_upper_byte = 1'b0;
    logic mux_mode = 1'b0, ready_enable = 1'b0, ready_active_high = 1'b1, ready_async = 1'b0;
    logic [7:0]  phase_time_unit = 8'h00;
    logic [0:0]  address_setup_phase = 1'h0, write_setup_tristate_phase = 1'h0;
    logic [1:0]  address_window_extra = 2'h0, command_delay_phase = 2'h0, hold_phase = 2'h0;
    logic [4:0]  access_phase = 5'h00;
    logic [23:0] req_addr = 24'h000000, separate_address_lines, cap_addr;
    logic [15:0] req_wdata = 16'h0000, rd_data, shared_bus_lines_out, separate_data_lines_out, mem_data, cap_sep, cap_shr;
    logic [3:0]  ready_wait = 4'h2;
    logic        req_ready, done_pulse, shared_bus_lines_oe_n, separate_data_lines_oe_n, addr_latch_en;
    logic        rd_n, wr_n, upper_byte_select_n, ready_pin, cap_oe, cap_ub;
    int          fails = 0, checks_done = 0, n, base;
    always #2 core_clk = ~core_clk;
    external_bus_cycle_phase_sequencer u_external_bus_cycle_phase_sequencer (.core_clk, .rst_n,
        .phase_time_unit, .address_setup_phase, .address_window_extra, .command_delay_phase,
        .write_setup_tristate_phase, .access_phase, .hold_phase, .mux_mode, .ready_enable,
        .ready_active_high, .ready_async, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .req_upper_byte, .done_pulse, .rd_data, .separate_address_lines, .shared_bus_lines_out,
        .shared_bus_lines_oe_n, .shared_bus_lines_in(mem_data), .separate_data_lines_out,
        .separate_data_lines_oe_n, .separate_data_lines_in(mem_data), .addr_latch_en, .rd_n, .wr_n,
        .upper_byte_select_n, .ready_pin);
    ext_mem u_ext_mem (.core_clk, .rd_n, .wr_n, .addr(separate_address_lines), .ready_wait,
        .ready_hi(ready_active_high), .data(mem_data), .ready_pin);
    task check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // one bus cycle; n counts falling edges from take to done
    task run(input logic w, input logic [23:0] a, input logic [15:0] d);
        {cap_shr, cap_sep, cap_oe, cap_addr, cap_ub} = 'x;
        @(negedge core_clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (done_pulse !== 1'b1 && n < 300) begin
            if (addr_latch_en === 1'b1) cap_shr = shared_bus_lines_out;
            if (wr_n === 1'b0) begin
                cap_sep = mux_mode ? shared_bus_lines_out : separate_data_lines_out;
                cap_oe = mux_mode ? shared_bus_lines_oe_n : separate_data_lines_oe_n;
                cap_addr = separate_address_lines;
                cap_ub = upper_byte_select_n;
            end
            @(negedge core_clk);
            n++;
        end
    endtask
    task t_phases;
        for (int i = 0; i < 4; i++) begin
            {address_setup_phase, command_delay_phase, write_setup_tristate_phase} = {i[0], i[1:0], i[1]};
            hold_phase = 2'(3 - i);
            access_phase = (i == 3) ? 5'h1f : 5'(i * 10);
            run(1'b0, 24'(i * 16'h1111), 16'h0000);
            check(24'(n), 24'(i[0] + 1 + i + i[1] + access_phase + 1 + 3 - i), "phase length");
            check(24'(rd_data), 24'(16'(i * 16'h1111) ^ 16'h3c5a), "read data");
        end
        {address_setup_phase, command_delay_phase, write_setup_tristate_phase, hold_phase, access_phase} = '0;
        $display("test phases done");
    endtask
    task t_window;
        address_window_extra = 2'h3;
        run(1'b0, 24'h120040, 16'h0000);
        check(24'(n), 24'd5, "window change extension");
        run(1'b0, 24'h120042, 16'h0000);
        check(24'(n), 24'd2, "same window");
        address_window_extra = 2'h0;
        $display("test window done");
    endtask
    task t_write;
        for (int m = 0; m < 2; m++) begin
            mux_mode = m[0];
            req_upper_byte = m[0];
            run(1'b1, 24'h12a5c3, 16'hbe01 + 16'(m));
            check(24'(cap_ub), 24'(!m[0]), "upper byte select");
            check(24'(req_ready), 24'h1, "idle after cycle");
            check(24'(cap_sep), 24'(16'hbe01 + 16'(m)), "write data");
            check(24'(cap_oe), 24'h0, "write drive enable");
            check(cap_addr, 24'h12a5c3, "address lines");
            if (m == 1) check(24'(cap_shr), 24'ha5c3, "shared address phase");
        end
        mux_mode = 1'b0;
        req_upper_byte = 1'b0;
        $display("test write done");
    endtask
    task t_unit;
        phase_time_unit = 8'h02;
        run(1'b0, 24'h120200, 16'h0000);
        check(24'(n), 24'd6, "unit divider");
        check(24'(rd_data), 24'(16'h0200 ^ 16'h3c5a), "read with divider");
        phase_time_unit = 8'h00;
        $display("test unit done");
    endtask
    task t_ready;
        ready_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {ready_async, ready_active_high} = 2'(k);
            run(1'b0, 24'(24'h120100 + k), 16'h0000);
            if (k < 2) base = n;
            check(24'(n > 3), 24'h1, "ready wait state");
            if (k > 1) check(24'(n > base), 24'h1, "async costs more");
            check(24'(rd_data), 24'((16'h0100 + 16'(k)) ^ 16'h3c5a), "read after wait");
        end
        {ready_enable, ready_async, ready_active_high} = 3'b001;
        $display("test ready done");
    endtask
    task summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) rst_n = 1'b1;
        t_phases();
        t_window();
        t_write();
        t_unit();
        t_ready();
        summarize();
    end
endmodule
`default_nettype wire
